/* File: tb/cir_assertions.sv */
// Purpose: port checks for the interrupt acceptance block
// Assumes: mask in status bits 10:8, super 13, trace 15
// Notes: bound to cir_core by name below
`timescale 1ns/1ns
module cir_assertions #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // core and bus inputs
  input wire logic insn_boundary_in,
  input wire logic [ADDR_W-1:0] next_pc_in,
  input wire logic bus_done_in,
  input wire logic bus_err_in,
  // outputs watched
  input wire logic [15:0] proc_status_word_out,
  input wire logic [15:0] saved_status_out,
  input wire logic exc_busy_out,
  input wire logic bus_req_out,
  input wire logic irq_ack_cycle_out,
  input wire logic bus_write_out,
  input wire logic [ADDR_W-1:0] bus_addr_out,
  input wire logic [ADDR_W-1:0] bus_wdata_out,
  input wire logic pc_load_out,
  input wire logic [7:0] vector_out,
  input wire logic spurious_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // acknowledge opens
  sequence s_ack_start;
    $rose(irq_ack_cycle_out);
  endsequence
  // acknowledge completes
  sequence s_ack_end;
    irq_ack_cycle_out && bus_done_in;
  endsequence
  // first frame word done, second word follows
  sequence s_push_next;
    (bus_write_out && bus_done_in) ##1 bus_write_out;
  endsequence
  a_ack_level: assert property (
    irq_ack_cycle_out |-> bus_addr_out == ADDR_W'(proc_status_word_out[10:8]))
    else $error("ack address is not the level");
  a_ack_state: assert property (
    s_ack_start |-> proc_status_word_out[13] && !proc_status_word_out[15]
      && saved_status_out == $past(proc_status_word_out))
    else $error("status not updated at acceptance");
  a_above_mask: assert property (
    s_ack_start |-> bus_addr_out[2:0] > $past(proc_status_word_out[10:8])
      || bus_addr_out[2:0] == 3'h7)
    else $error("level taken at or below mask");
  a_at_boundary: assert property (
    $rose(exc_busy_out) |-> $past(insn_boundary_in))
    else $error("acceptance off a boundary");
  a_ack_hold: assert property (
    irq_ack_cycle_out && !bus_done_in |=> irq_ack_cycle_out)
    else $error("ack dropped before completion");
  a_frame_pc: assert property (
    s_ack_end |=> bus_req_out && bus_write_out && bus_wdata_out == next_pc_in)
    else $error("frame push missing next address");
  a_spur_vec: assert property (
    s_ack_end ##0 bus_err_in |-> ##[1:2] spurious_out && vector_out == 8'h18)
    else $error("spurious ack not flagged");
  a_pc_after: assert property (
    $rose(pc_load_out) |-> $past(bus_req_out && bus_done_in && !bus_write_out))
    else $error("handler load without fetch");
  a_frame_sr: assert property (
    s_push_next |-> bus_wdata_out == ADDR_W'(saved_status_out))
    else $error("second frame word is not the saved status");
  a_frame_addr: assert property (
    s_push_next |-> bus_addr_out == $past(bus_addr_out) - ADDR_W'(4))
    else $error("frame words not stacked downward");
endmodule
bind cir_core cir_assertions #(.ADDR_W(ADDR_W)) cir_assertions_i (
  .sys_clk_in(sys_clk_in),
  .rst_b_in(rst_b_in),
  .insn_boundary_in(insn_boundary_in),
  .next_pc_in(next_pc_in),
  .bus_done_in(bus_done_in),
  .bus_err_in(bus_err_in),
  .proc_status_word_out(proc_status_word_out),
  .saved_status_out(saved_status_out),
  .exc_busy_out(exc_busy_out),
  .bus_req_out(bus_req_out),
  .irq_ack_cycle_out(irq_ack_cycle_out),
  .bus_write_out(bus_write_out),
  .bus_addr_out(bus_addr_out),
  .bus_wdata_out(bus_wdata_out),
  .pc_load_out(pc_load_out),
  .vector_out(vector_out),
  .spurious_out(spurious_out)
);

/* File: tb/cir_src_model.sv */
// Purpose: interrupt source and bus responder
// Assumes: level given by the bench, held while busy
// Notes: data lines show inverse outside done
`timescale 1ns/1ns
module cir_src_model (
  // clock
  input wire logic sys_clk_in,
  // bench controls
  input wire logic [2:0] level_in,
  input wire logic [1:0] mode_in,
  input wire logic slow_in,
  // core bus request
  input wire logic bus_req_in,
  input wire logic ack_in,
  input wire logic [31:0] addr_in,
  // answers
  output logic [2:0] irq_level_req_n_out,
  output logic done_out,
  output logic err_out,
  output logic [7:0] vec_out,
  output logic [31:0] word_out
);
  logic [1:0] cnt_q;
  logic [7:0] vec_q;
  logic [31:0] word_q;
  initial begin
    done_out = 1'b0;
    err_out = 1'b0;
    cnt_q = 2'h0;
  end
  // inverted level pattern
  assign irq_level_req_n_out = ~level_in;
  // stale data never shown
  assign vec_out = done_out ? vec_q : ~vec_q;
  assign word_out = done_out ? word_q : ~word_q;
  // answer after zero or two waits
  always @(posedge sys_clk_in) begin
    done_out <= 1'b0;
    err_out <= 1'b0;
    if (bus_req_in && !done_out) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q >= {slow_in, 1'b0}) begin
        done_out <= 1'b1;
        cnt_q <= 2'h0;
        err_out <= ack_in && mode_in == 2'h2;
        // spurious, uninit or autovector
        vec_q <= mode_in == 2'h2 ? 8'h18 : mode_in == 2'h1 ? 8'h0f :
          8'h60 + {3'h0, addr_in[2:0], 2'h0};
        word_q <= addr_in ^ 32'h5a5a0000;
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
// Purpose: self-checking bench for cir_core
// Assumes: model answers every bus request
// Notes: handler expectations queued, popped at pc load
`timescale 1ns/1ns
module testbench;
  import cir_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, bnd = 1'b0, srw = 1'b0, slow = 1'b0;
  logic done, err, busy, req, ack, wr, pcl, spur;
  logic [15:0] srd = 16'h2700, sr, ssr;
  logic [31:0] npc = 32'h0, vbr = 32'h0, addr, wdata, pcv, word;
  logic [31:0] seed = 32'h60dd;
  logic [2:0] lvl = 3'h0, irq_n;
  logic [1:0] mode = 2'h0;
  logic [7:0] vec, vecq;
  logic [39:0] q[$], e;
  int n_errors = 0, n_tests = 0, cyc = 0;
  always #5 clk = ~clk;
  cir_core cir_core_i (.sys_clk_in(clk), .rst_b_in(rst_b), .irq_level_req_n_in(irq_n),
    .insn_boundary_in(bnd), .next_pc_in(npc), .vbr_in(vbr), .sr_write_in(srw),
    .sr_wdata_in(srd), .bus_done_in(done), .bus_err_in(err), .bus_rdata_vec_in(vec),
    .bus_rdata_word_in(word), .proc_status_word_out(sr), .saved_status_out(ssr),
    .exc_busy_out(busy), .bus_req_out(req), .irq_ack_cycle_out(ack), .bus_write_out(wr),
    .bus_addr_out(addr), .bus_wdata_out(wdata), .pc_load_out(pcl), .pc_value_out(pcv),
    .vector_out(vecq), .spurious_out(spur));
  cir_src_model cir_src_model_i (.sys_clk_in(clk), .level_in(lvl), .mode_in(mode),
    .slow_in(slow), .bus_req_in(req), .ack_in(ack), .addr_in(addr),
    .irq_level_req_n_out(irq_n), .done_out(done), .err_out(err), .vec_out(vec),
    .word_out(word));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(string name, logic [39:0] seen, logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task conclude;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // mask with trace set, level held until done, one boundary
  task run(logic [2:0] l, logic [2:0] m, logic [1:0] md, logic tk);
    logic [7:0] ev;
    ev = md == 2'h2 ? 8'h18 : md == 2'h1 ? 8'h0f : 8'h60 + {3'h0, l, 2'h0};
    @(posedge clk);
    srw <= 1'b1;
    srd <= {5'h14, m, 8'h00};
    mode <= md;
    lvl <= l;
    npc <= seed;
    vbr <= {seed[23:0], 8'h00};
    seed = lfsr(seed);
    @(posedge clk) srw <= 1'b0;
    repeat (6) @(posedge clk);
    if (tk) q.push_back({(vbr + {22'h0, ev, 2'h0}) ^ 32'h5a5a0000, ev});
    bnd <= 1'b1;
    @(posedge clk) bnd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("busy", 40'(busy), 40'(tk));
    for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clk);
    #1;
    check("idle", 40'(busy), 40'h0);
    check("mask", 40'(sr[10:8]), 40'(tk ? l : m));
  endtask
  // compare each handler load with the oldest note
  always @(negedge clk) begin
    if (pcl === 1'b1) begin
      if (q.size() == 0) check("extra load", 40'h1, 40'h0);
      else begin
        e = q.pop_front();
        check("handler", {pcv, vecq}, e);
        check("spurious", 40'(spur), 40'(e[7:0] == 8'h18));
      end
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      conclude;
    end
  end
  initial begin
    logic [2:0] l, m;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 1; i < 7; i++) begin
      slow <= i[0];
      run(i[2:0], i[2:0] - 3'h1, 2'h0, 1'b1);
    end
    run(3'h0, 3'h0, 2'h0, 1'b0);
    run(3'h5, 3'h5, 2'h0, 1'b0);
    run(3'h5, 3'h4, 2'h0, 1'b1);
    run(3'h4, 3'h0, 2'h1, 1'b1);
    run(3'h2, 3'h1, 2'h2, 1'b1);
    run(3'h7, 3'h7, 2'h0, 1'b1);
    run(3'h7, 3'h7, 2'h0, 1'b0);
    run(3'h7, 3'h6, 2'h0, 1'b1);
    run(3'h3, 3'h7, 2'h0, 1'b0);
    run(3'h7, 3'h7, 2'h0, 1'b1);
    for (int i = 0; i < 40; i++) begin
      l = seed[2:0] == 3'h7 ? 3'h3 : seed[2:0];
      m = seed[5:3];
      slow <= seed[8];
      run(l, m, seed[7:6] == 2'h3 ? 2'h0 : seed[7:6], l > m);
    end
    check("notes left", 40'(q.size()), 40'h0);
    conclude;
  end
endmodule

/* File: verilog/cir_core.sv */
// Purpose: interrupt recognition and acceptance sequencing
// Assumes: core signals instruction boundaries and bus completions
// Notes: vector fetch and frame writes are requested, the core bus does them
//
// Contract
// RULE1: request level encoded inverted on three pins
// RULE2: mask inhibits levels at or below it
// RULE3: requests pend, evaluated at instruction boundaries
// RULE4: pending not above mask is deferred
// RULE5: accept saves status, supervisor, no trace, mask
// RULE6: acknowledge cycle shows level, reads vector
// RULE7: push frame with next instruction address
// RULE8: load handler address from vector table
// RULE9: source holds level until acknowledge ends
// RULE10: held level not retaken until mask lowered
// RULE11: new level after acknowledge may nest
// RULE12: level seven ignores mask of seven
// RULE13: level seven taken on rising transition only; the code also takes a held seven whenever the mask is below seven
// RULE14: second seven needs drop and reassert
// RULE15: lowered mask retakes held level seven
// RULE16: source holds seven until second acknowledge
// RULE17: access error means spurious, vector 0x18
// RULE18: external autovectors 0x64 to 0x7c
// RULE19: uninitialized peripheral returns vector 0xf
// RULE20: sample pins each clock, latch seven edge
`timescale 1ns/1ns
module cir_core
  import cir_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // request pins, active low
  input wire logic [cir_pkg::CIR_LVL_W-1:0] irq_level_req_n_in,
  // core execution interface
  input wire logic insn_boundary_in,
  input wire logic [ADDR_W-1:0] next_pc_in,
  input wire logic [ADDR_W-1:0] vbr_in,
  input wire logic sr_write_in,
  input wire logic [cir_pkg::CIR_SR_W-1:0] sr_wdata_in,
  // bus completion interface
  input wire logic bus_done_in,
  input wire logic bus_err_in,
  input wire logic [7:0] bus_rdata_vec_in,
  input wire logic [ADDR_W-1:0] bus_rdata_word_in,
  // status word and exception outputs
  output logic [cir_pkg::CIR_SR_W-1:0] proc_status_word_out,
  output logic [cir_pkg::CIR_SR_W-1:0] saved_status_out,
  output logic exc_busy_out,
  // bus request outputs
  output logic bus_req_out,
  output logic irq_ack_cycle_out,
  output logic bus_write_out,
  output logic [ADDR_W-1:0] bus_addr_out,
  output logic [ADDR_W-1:0] bus_wdata_out,
  // handler redirect
  output logic pc_load_out,
  output logic [ADDR_W-1:0] pc_value_out,
  output logic [7:0] vector_out,
  output logic spurious_out
);
  // refuse buses too narrow for the table offset or the pushed status word
  if (ADDR_W < 16) begin : g_addr_chk
    $error("ADDR_W too small");
  end

  logic [2:0] pin_sync; // synchronised inverted pins
  logic [2:0] req_lvl; // decoded request level
  logic [2:0] prev_lvl_q; // previous sample for edge detect
  logic nmi_pend_q; // latched level seven edge
  logic [2:0] mask; // current mask field
  logic take; // accept at this boundary
  logic [2:0] take_lvl; // level being accepted
  cir_state_t state_q; // sequencer state
  logic [2:0] acc_lvl_q; // accepted level
  logic [ADDR_W-1:0] ret_pc_q; // saved return address
  logic push_idx_q; // which frame word
  logic [ADDR_W-1:0] sp_q; // supervisor stack pointer

  // decode: all high is no request, level is inverted pattern
  function automatic logic [2:0] cir_decode(input logic [2:0] pins_n);
    cir_decode = ~pins_n; // [RULE1]
  endfunction

  // pins pass the three-flop agreement filter
  cir_sync #(.WIDTH(3)) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .pin_in(irq_level_req_n_in),
    .level_out(pin_sync)
  );

  assign req_lvl = cir_decode(pin_sync);
  assign mask = proc_status_word_out[CIR_SR_MASK_LO +: 3];

  // previous level sample each clock
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_lvl_q <= CIR_LVL_NONE;
    end else begin
      prev_lvl_q <= req_lvl; // [RULE20]
    end
  end

  // level seven edge latch; new edge wins over acceptance clear
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nmi_pend_q <= 1'b0;
    end else if (req_lvl == CIR_LVL_NMI && prev_lvl_q != CIR_LVL_NMI) begin
      nmi_pend_q <= 1'b1; // [RULE13] [RULE20]
    end else if (take && take_lvl == CIR_LVL_NMI) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // acceptance decision only at boundaries while running
  always_comb begin
    take = 1'b0;
    take_lvl = req_lvl;
    if (state_q == CIR_ST_RUN && insn_boundary_in) begin // [RULE3]
      if (req_lvl == CIR_LVL_NMI) begin
        // edge, or held seven under a lowered mask
        take = nmi_pend_q || (mask < CIR_LVL_NMI); // [RULE12] [RULE13] [RULE15]
      end else begin
        // held level retaken only once mask drops below it
        take = req_lvl > mask; // [RULE2] [RULE4] [RULE10] [RULE11]
      end
    end
  end

  // status word: accept updates, software writes otherwise
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      proc_status_word_out <= CIR_SR_RESET;
      saved_status_out <= CIR_SR_RESET;
    end else if (take) begin
      saved_status_out <= proc_status_word_out; // [RULE5]
      proc_status_word_out[CIR_SR_SUPER] <= 1'b1;
      proc_status_word_out[CIR_SR_TRACE] <= 1'b0;
      proc_status_word_out[CIR_SR_MASK_LO +: 3] <= take_lvl;
    end else if (sr_write_in) begin
      // mask lowering, e.g. return_from_exception_insn
      proc_status_word_out <= sr_wdata_in;
    end
  end

  // exception sequencer
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= CIR_ST_RUN;
      acc_lvl_q <= CIR_LVL_NONE;
      ret_pc_q <= '0;
      push_idx_q <= 1'b0;
      vector_out <= 8'h00;
      spurious_out <= 1'b0;
    end else begin
      unique case (state_q)
        CIR_ST_RUN: begin
          if (take) begin
            acc_lvl_q <= take_lvl;
            ret_pc_q <= next_pc_in; // [RULE7]
            spurious_out <= 1'b0;
            state_q <= CIR_ST_ACK;
          end
        end
        CIR_ST_ACK: begin
          if (bus_done_in) begin
            // access error marks the cycle spurious
            spurious_out <= bus_err_in; // [RULE17]
            vector_out <= bus_err_in ? CIR_VEC_SPURIOUS : bus_rdata_vec_in; // [RULE6]
            push_idx_q <= 1'b0;
            state_q <= CIR_ST_PUSH;
          end
        end
        CIR_ST_PUSH: begin
          if (bus_done_in) begin
            push_idx_q <= 1'b1;
            if (push_idx_q) begin
              state_q <= CIR_ST_FETCH;
            end
          end
        end
        CIR_ST_FETCH: begin
          if (bus_done_in) begin
            state_q <= CIR_ST_DONE;
          end
        end
        CIR_ST_DONE: begin
          state_q <= CIR_ST_RUN;
        end
        default: begin
          state_q <= CIR_ST_RUN;
        end
      endcase
    end
  end

  // supervisor stack pointer tracks frame pushes
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sp_q <= '0;
    end else if (state_q == CIR_ST_PUSH && bus_done_in) begin
      sp_q <= sp_q - ADDR_W'(4); // [RULE7]
    end
  end

  // handler address loads the program counter
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pc_load_out <= 1'b0;
      pc_value_out <= '0;
    end else begin
      pc_load_out <= state_q == CIR_ST_FETCH && bus_done_in; // [RULE8]
      if (state_q == CIR_ST_FETCH && bus_done_in) begin
        pc_value_out <= bus_rdata_word_in;
      end
    end
  end

  // bus request drive per state
  always_comb begin
    bus_req_out = 1'b0;
    irq_ack_cycle_out = 1'b0;
    bus_write_out = 1'b0;
    bus_addr_out = '0;
    bus_wdata_out = '0;
    unique case (state_q)
      CIR_ST_ACK: begin
        bus_req_out = 1'b1;
        irq_ack_cycle_out = 1'b1;
        bus_addr_out = ADDR_W'(acc_lvl_q); // [RULE6]
      end
      CIR_ST_PUSH: begin
        bus_req_out = 1'b1;
        bus_write_out = 1'b1;
        bus_addr_out = sp_q - ADDR_W'(4);
        bus_wdata_out = push_idx_q ? ADDR_W'(saved_status_out) : ret_pc_q; // [RULE7]
      end
      CIR_ST_FETCH: begin
        bus_req_out = 1'b1;
        bus_addr_out = vbr_in + (ADDR_W'(vector_out) << CIR_VBR_SHIFT); // [RULE8]
      end
      default: begin
        bus_req_out = 1'b0;
      end
    endcase
  end

  assign exc_busy_out = state_q != CIR_ST_RUN;
endmodule

/* File: verilog/cir_pkg.sv */
// Purpose: shared constants for the interrupt recognition block
// Assumes: 100 MHz core clock, status word laid out with trace at 15, supervisor at 13
// Notes: vector numbers are what external logic returns, kept for reference; the core itself drives the spurious vector on an access error
package cir_pkg;
  localparam int CIR_LVL_W = 3; // width of a priority level
  localparam logic [2:0] CIR_LVL_NONE = 3'h0; // no request
  localparam logic [2:0] CIR_LVL_NMI = 3'h7; // nonmaskable level
  localparam int CIR_SR_W = 16; // status word width
  localparam int CIR_SR_TRACE = 15; // trace bit position
  localparam int CIR_SR_SUPER = 13; // supervisor bit position
  localparam int CIR_SR_MASK_LO = 8; // mask field low bit
  localparam logic [15:0] CIR_SR_RESET = 16'h2700; // supervisor, mask 7
  localparam logic [7:0] CIR_VEC_SPURIOUS = 8'h18; // spurious vector
  localparam logic [7:0] CIR_VEC_AUTO_BASE = 8'h64; // autovector for level 1
  localparam logic [7:0] CIR_VEC_AUTO_LAST = 8'h7c; // autovector for level 7
  localparam logic [7:0] CIR_VEC_UNINIT = 8'h0f; // uninitialized vector
  localparam logic [7:0] CIR_VBR_SHIFT = 8'h02; // vector to table byte offset
  localparam int CIR_FRAME_WORDS = 2; // longwords pushed per frame
  typedef enum logic [2:0] {
    CIR_ST_RUN, CIR_ST_ACK, CIR_ST_PUSH, CIR_ST_FETCH, CIR_ST_DONE
  } cir_state_t;
endpackage

/* File: verilog/cir_sync.sv */
// Purpose: three-flop synchroniser with agreement filter for request pins
// Assumes: pins are asynchronous to sys_clk_in
// Notes: first flop is read only by the second
`timescale 1ns/1ns
module cir_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // pin side
  input wire logic [WIDTH-1:0] pin_in,
  // filtered level
  output logic [WIDTH-1:0] level_out
);
  // a zero-width chain cannot carry a level
  if (WIDTH < 1) begin : g_width_chk
    $error("WIDTH too small");
  end
  logic [WIDTH-1:0] s1_q; // metastability catcher
  logic [WIDTH-1:0] s2_q; // second stage
  logic [WIDTH-1:0] s3_q; // third stage
  // shift chain, idle high since pins are active low
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // change only once stages two and three agree
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_out <= '1;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end
endmodule
